//--- ccsp_pkg.sv
// Purpose: shared constants and carriers for the CPU to CAN SFR port
// Assumes: 8-bit SFR bus, 8-bit direct and bit addresses
// Notes: one package, used by scoped names only
package ccsp_pkg;
	// ==========================================================
	// SFR locations
	localparam logic [7:0] SFR_STATUS_RAMADR = 8'hD8;
	localparam logic [7:0] SFR_IRQ_CMD = 8'hD9;
	localparam logic [7:0] SFR_DATA_WINDOW = 8'hDA;
	localparam logic [7:0] SFR_SELECTOR = 8'hDB;
	// Bit addresses of the status/RAM-address register, bit 0 .. bit 7
	localparam logic [7:0] BIT_STATUS_FIRST = 8'hD8;
	localparam logic [7:0] BIT_STATUS_LAST = 8'hDF;
	// ==========================================================
	// Selector layout and reset value
	localparam int SEL_DMA_POS = 7;
	localparam int SEL_RSVD_POS = 6;
	localparam int SEL_AUTO_INCREMENT_ENABLE_POS = 5;
	localparam int SEL_INDEX_W = 5;
	localparam logic [7:0] SELECTOR_RESET = 8'h64;
	localparam logic [7:0] DMA_RAM_ADDR_RESET = 8'h00;
	// Interrupt read image: reserved top bits read high
	localparam logic [2:0] IRQ_RSVD_ONES = 3'h7;
	localparam int IRQ_FLAG_W = 5;
	// ==========================================================
	// SFR bus request
	typedef struct packed {
		logic rd;
		logic wr;
		logic bit_wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic bit_val;
	} ccsp_sfr_req_t;
	// Interrupt flags, bit 4 .. bit 0
	typedef struct packed {
		logic wake_up_irq_flag;
		logic overrun_irq_flag;
		logic error_irq_flag;
		logic transmit_irq_flag;
		logic receive_irq_flag;
	} ccsp_irq_t;
	// Status flags, bit 7 .. bit 0
	typedef struct packed {
		logic bus_off_state_flag;
		logic error_state_flag;
		logic transmitting_flag;
		logic receiving_flag;
		logic transmission_complete_flag;
		logic transmit_buffer_access_flag;
		logic data_overrun_flag;
		logic receive_buffer_full_flag;
	} ccsp_status_t;
	// Command strobe bits, bit 7 .. bit 0
	typedef struct packed {
		logic first_receive_input_active;
		logic second_receive_input_active;
		logic wake_up_mode_cmd;
		logic sleep_cmd;
		logic clear_overrun_cmd;
		logic release_receive_buffer_cmd;
		logic abort_transmission_cmd;
		logic transmission_request_cmd;
	} ccsp_cmd_t;
endpackage

//--- ccsp_regfile.sv
// Purpose: internal CAN register file reached through the data window
// Assumes: one access per cycle, a read of an entry written in the same cycle returns the old value
// Notes: read data come out of a register, one cycle after the request
`timescale 1ns/100ps
module ccsp_regfile #(
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic clk,
	input wire logic rd,
	input wire logic wr,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	// ==========================================================
	// Storage
	logic [7:0] mem [DEPTH];

	// Elaboration check: the index must reach every entry
	if (DEPTH > (1 << AW) || DEPTH < 1)
	begin
		$error("ccsp_regfile: DEPTH does not fit AW");
	end

	// Write port
	always_ff @(posedge clk)
	begin
		if (wr)
			mem[addr] <= wdata;
	end

	// Registered read port
	always_ff @(posedge clk)
	begin
		if (rd)
			rdata <= mem[addr];
	end
endmodule

//--- ccsp_port.sv
// Purpose: SFR port from the CPU to the CAN register file and DMA logic
// Assumes: CPU reads are answered one cycle after the request, window reads two cycles after
// Notes: controller flags arrive on the CPU clock, no synchroniser
//
// What this block does
// - Selector register read/write at DBH
// - Low five selector bits index window target
// - Selector resets to 64H
// - Selector bit 7 starts DMA transfer
// - Selector bit 5 enables auto increment
// - Data window read/write at DAH
// - Window reads/writes indexed internal register
// - D9H read returns interrupt register
// - Interrupt read bits 7..5 read one
// - Interrupt bits 4..0: WU,OVR,ERR,TX,RX
// - D9H write goes to command register
// - Command bits carry the eight command meanings
// - Status register bit addressable DFH..D8H
// - Status register read returns controller status
// - Status read bits: bus..receive buffer order
// - Status write latches DMA RAM address
// - Reserved interface bits read as one
// - Auto increment bumps selector per window access
// - DMA bit self clears on completion
`timescale 1ns/100ps
module ccsp_port #(
	parameter int REG_DEPTH = 32
) (
	input wire logic CLK,
	input wire logic RST,
	input wire ccsp_pkg::ccsp_sfr_req_t SFR_REQ,
	input wire ccsp_pkg::ccsp_irq_t IRQ_FLAGS,
	input wire ccsp_pkg::ccsp_status_t STATUS_FLAGS,
	input wire logic DMA_DONE,
	output logic [7:0] SFR_RDATA,
	output logic SFR_RVALID,
	output ccsp_pkg::ccsp_cmd_t CMD_STROBE,
	output logic CMD_VALID,
	output logic DMA_START,
	output logic [7:0] DMA_RAM_ADDR,
	output logic [4:0] DMA_BUF_INDEX,
	output logic DMA_ACTIVE
);
	// ==========================================================
	// Decode
	logic [7:0] selector;
	logic [7:0] next_selector;
	logic sel_hit;
	logic win_hit;
	logic irq_hit;
	logic sta_hit;
	logic sta_bit_hit;
	logic win_rd;
	logic win_wr;
	logic [7:0] win_rdata;
	logic [2:0] bit_pos;
	logic [7:0] status_image;
	logic [7:0] irq_image;
	logic [7:0] selector_image;
	logic [7:0] next_rdata;
	logic rd_window_q;

	// ==========================================================
	// Parameter check
	// Five index bits, so a deeper file could never be reached
	if (REG_DEPTH < 1 || REG_DEPTH > (1 << ccsp_pkg::SEL_INDEX_W))
	begin
		$error("ccsp_port: REG_DEPTH does not fit the selector index");
	end

	// Byte locations and the status bit range
	assign sel_hit = SFR_REQ.addr == ccsp_pkg::SFR_SELECTOR;
	assign win_hit = SFR_REQ.addr == ccsp_pkg::SFR_DATA_WINDOW;
	assign irq_hit = SFR_REQ.addr == ccsp_pkg::SFR_IRQ_CMD;
	assign sta_hit = SFR_REQ.addr == ccsp_pkg::SFR_STATUS_RAMADR;
	assign sta_bit_hit = SFR_REQ.addr >= ccsp_pkg::BIT_STATUS_FIRST &&
		SFR_REQ.addr <= ccsp_pkg::BIT_STATUS_LAST;
	assign bit_pos = SFR_REQ.addr[2:0];
	assign win_rd = SFR_REQ.rd && win_hit;
	assign win_wr = SFR_REQ.wr && win_hit;

	// ==========================================================
	// Read images
	// status bit order
	assign status_image = STATUS_FLAGS;
	assign irq_image = {ccsp_pkg::IRQ_RSVD_ONES, IRQ_FLAGS};
	assign selector_image = selector | (8'h01 << ccsp_pkg::SEL_RSVD_POS);

	// ==========================================================
	// Internal register file
	// window reaches indexed entry
	ccsp_regfile #(
		.DEPTH(REG_DEPTH),
		.AW(ccsp_pkg::SEL_INDEX_W)
	) u_regfile (
		.clk(CLK),
		.rd(win_rd),
		.wr(win_wr),
		.addr(selector[ccsp_pkg::SEL_INDEX_W-1:0]),
		.wdata(SFR_REQ.wdata),
		.rdata(win_rdata)
	);

	// ==========================================================
	// Selector next value
	always_comb
	begin
		next_selector = selector;
		if (SFR_REQ.wr && sel_hit)
			next_selector = SFR_REQ.wdata;
		else if ((win_rd || win_wr) && selector[ccsp_pkg::SEL_AUTO_INCREMENT_ENABLE_POS])
			next_selector = {selector[7:5],
				selector[4:0] + 5'h01};
		// completion clears DMA bit, a CPU selector write in the same cycle wins
		if (DMA_DONE && !(SFR_REQ.wr && sel_hit))
			next_selector[ccsp_pkg::SEL_DMA_POS] = 1'b0;
	end

	// Selector register
	always_ff @(posedge CLK)
	begin
		if (RST)
			selector <= ccsp_pkg::SELECTOR_RESET;
		else
			selector <= next_selector;
	end

	// ==========================================================
	// DMA RAM address, byte or single-bit write
	always_ff @(posedge CLK)
	begin
		if (RST)
			DMA_RAM_ADDR <= ccsp_pkg::DMA_RAM_ADDR_RESET;
		else if (SFR_REQ.wr && sta_hit)
			DMA_RAM_ADDR <= SFR_REQ.wdata;
		else if (SFR_REQ.bit_wr && sta_bit_hit)
			DMA_RAM_ADDR[bit_pos] <= SFR_REQ.bit_val;
	end

	// ==========================================================
	// DMA start and state
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			DMA_START <= 1'b0;
			DMA_BUF_INDEX <= 5'h00;
			DMA_ACTIVE <= 1'b0;
		end
		else
		begin
			// writing bit 7 high kicks transfer
			DMA_START <= SFR_REQ.wr && sel_hit &&
				SFR_REQ.wdata[ccsp_pkg::SEL_DMA_POS];
			if (SFR_REQ.wr && sel_hit)
				DMA_BUF_INDEX <= SFR_REQ.wdata[4:0];
			DMA_ACTIVE <= next_selector[ccsp_pkg::SEL_DMA_POS];
		end
	end

	// ==========================================================
	// Command strobe
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			CMD_STROBE <= '0;
			CMD_VALID <= 1'b0;
		end
		else
		begin
			// write at D9H is a command
			CMD_VALID <= SFR_REQ.wr && irq_hit;
			CMD_STROBE <= (SFR_REQ.wr && irq_hit) ? SFR_REQ.wdata : 8'h00;
		end
	end

	// ==========================================================
	// Read data mux for non-window locations
	always_comb
	begin
		next_rdata = 8'hFF;
		if (sel_hit)
			next_rdata = selector_image;
		else if (irq_hit)
			next_rdata = irq_image;
		else if (sta_hit)
			next_rdata = status_image;
	end

	// Read pipeline; window data join from the file output
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			SFR_RDATA <= 8'hFF;
			SFR_RVALID <= 1'b0;
			rd_window_q <= 1'b0;
		end
		else
		begin
			rd_window_q <= 1'b0;
			SFR_RVALID <= SFR_REQ.rd && !win_hit;
			if (SFR_REQ.rd && !win_hit)
				SFR_RDATA <= next_rdata;
			// Window read costs one extra cycle
			if (win_rd)
				rd_window_q <= 1'b1;
			if (rd_window_q)
			begin
				SFR_RDATA <= win_rdata;
				SFR_RVALID <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Checks
	sequence s_cmd_write;
		SFR_REQ.wr && irq_hit;
	endsequence

	sequence s_strobe_once;
		CMD_VALID ##1 !CMD_VALID;
	endsequence

	// Window read: file read first, answer one cycle later
	sequence s_win_answer;
		##1 rd_window_q ##1 (SFR_RVALID && SFR_RDATA == $past(win_rdata));
	endsequence

	// Selector write with the DMA bit set
	sequence s_dma_kick;
		SFR_REQ.wr && sel_hit && SFR_REQ.wdata[ccsp_pkg::SEL_DMA_POS];
	endsequence

	AST_RESET_VALUE: assert property (@(posedge CLK)
		RST |=> selector == 8'h64)
		else $error("selector reset value wrong");

	AST_CMD_PULSE: assert property (@(posedge CLK) disable iff (RST)
		s_cmd_write ##1 !(SFR_REQ.wr && irq_hit) |-> s_strobe_once)
		else $error("command strobe held too long");

	AST_CMD_DATA: assert property (@(posedge CLK) disable iff (RST)
		s_cmd_write |=> CMD_VALID && CMD_STROBE == $past(SFR_REQ.wdata))
		else $error("command data not delivered");

	AST_IRQ_READ: assert property (@(posedge CLK) disable iff (RST)
		SFR_REQ.rd && irq_hit |=> SFR_RVALID && SFR_RDATA[7:5] == 3'h7 &&
		SFR_RDATA[4:0] == $past(IRQ_FLAGS))
		else $error("interrupt read image wrong");

	AST_STATUS_READ: assert property (@(posedge CLK) disable iff (RST)
		SFR_REQ.rd && sta_hit |=> SFR_RDATA == $past(STATUS_FLAGS))
		else $error("status read image wrong");

	AST_SEL_RSVD: assert property (@(posedge CLK) disable iff (RST)
		SFR_REQ.rd && sel_hit |=> SFR_RDATA[6])
		else $error("reserved selector bit not one");

	AST_AUTO_INCREMENT_ENABLE: assert property (@(posedge CLK) disable iff (RST)
		win_wr && selector[5] && !DMA_DONE |=>
		selector[4:0] == $past(selector[4:0]) + 5'h01)
		else $error("auto increment missing");

	AST_NO_INC: assert property (@(posedge CLK) disable iff (RST)
		(win_rd || win_wr) && !selector[5] |=> $stable(selector[4:0]))
		else $error("index moved without auto increment");

	AST_DMA_CLEAR: assert property (@(posedge CLK) disable iff (RST)
		DMA_DONE && !(SFR_REQ.wr && sel_hit) |=> !selector[7] && !DMA_ACTIVE)
		else $error("DMA bit not cleared");

	AST_RAM_ADDR: assert property (@(posedge CLK) disable iff (RST)
		SFR_REQ.wr && sta_hit |=> DMA_RAM_ADDR == $past(SFR_REQ.wdata))
		else $error("DMA RAM address not latched");

	AST_WIN_READ: assert property (@(posedge CLK) disable iff (RST)
		win_rd |-> ##2 SFR_RVALID)
		else $error("window read gave no answer");

	// Window path: data of the file reach the CPU, writes land
	AST_WIN_DATA: assert property (@(posedge CLK) disable iff (RST)
		win_rd |-> s_win_answer)
		else $error("window read data lost");

	AST_WIN_WRITE: assert property (@(posedge CLK) disable iff (RST)
		win_wr |=>
		u_regfile.mem[$past(selector[4:0])] == $past(SFR_REQ.wdata))
		else $error("window write missed indexed entry");

	// Selector byte access
	AST_SEL_WRITE: assert property (@(posedge CLK) disable iff (RST)
		SFR_REQ.wr && sel_hit |=> selector == $past(SFR_REQ.wdata))
		else $error("selector write lost");

	AST_SEL_READ: assert property (@(posedge CLK) disable iff (RST)
		SFR_REQ.rd && sel_hit |=>
		SFR_RVALID && SFR_RDATA == ($past(selector) | 8'h40))
		else $error("selector read image wrong");

	// DMA kick is one pulse and loads the buffer index
	AST_DMA_START: assert property (@(posedge CLK) disable iff (RST)
		s_dma_kick |=> DMA_START && DMA_ACTIVE &&
		DMA_BUF_INDEX == $past(SFR_REQ.wdata[4:0]))
		else $error("DMA start missing");

	AST_DMA_PULSE: assert property (@(posedge CLK) disable iff (RST)
		!(SFR_REQ.wr && sel_hit) |=> !DMA_START)
		else $error("DMA start without selector write");

	// Single bit write of the RAM address
	AST_RAM_BIT: assert property (@(posedge CLK) disable iff (RST)
		SFR_REQ.bit_wr && sta_bit_hit && !SFR_REQ.wr |=>
		DMA_RAM_ADDR[$past(bit_pos)] == $past(SFR_REQ.bit_val))
		else $error("DMA RAM address bit not written");

	// Command bits must not leak outside the strobe cycle
	AST_CMD_IDLE: assert property (@(posedge CLK) disable iff (RST)
		!CMD_VALID |-> CMD_STROBE == 8'h00)
		else $error("command bits without strobe");

	// Outputs quiet after reset
	AST_RESET_OUT: assert property (@(posedge CLK)
		RST |=> !SFR_RVALID && !CMD_VALID && !DMA_START && !DMA_ACTIVE &&
		DMA_RAM_ADDR == ccsp_pkg::DMA_RAM_ADDR_RESET)
		else $error("outputs not cleared by reset");
endmodule

//--- ccsp_cpu_model.sv
// Purpose: CPU side of the SFR bus, byte and bit cycles
// Assumes: requests are one-cycle pulses launched at a rising edge
// Notes: read waits a bounded time for the answer strobe
`timescale 1ns/100ps
module ccsp_cpu_model (
	input wire logic CLK,
	input wire logic [7:0] SFR_RDATA,
	input wire logic SFR_RVALID,
	output ccsp_pkg::ccsp_sfr_req_t SFR_REQ
);
	// ==========================================
	// Bus cycles
	initial SFR_REQ = '0;
	task automatic cyc(input logic r, w, b, input logic [7:0] a, d);
		@(posedge CLK);
		SFR_REQ <= '{rd: r, wr: w, bit_wr: b, addr: a, wdata: d,
			bit_val: d[0]};
		@(posedge CLK);
		SFR_REQ <= '0;
	endtask
	// Three idle cycles cover the window answer two cycles after the request
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		q = 'x;
		cyc(1'h1, 1'h0, 1'h0, a, 8'h00);
		repeat (3)
		begin
			@(negedge CLK);
			if (SFR_RVALID === 1'h1)
				q = SFR_RDATA;
		end
	endtask
endmodule

//--- tb_cpu_can_sfr_port.sv
// Purpose: self-checking bench for the CPU to CAN SFR port
// Assumes: CPU model drives every request
// Notes: controller flags and DMA completion driven here
`timescale 1ns/100ps
module tb_cpu_can_sfr_port;
	logic CLK = 1'h0;
	logic RST = 1'h1;
	ccsp_pkg::ccsp_sfr_req_t req;
	ccsp_pkg::ccsp_irq_t irq = '0;
	ccsp_pkg::ccsp_status_t sta = '0;
	ccsp_pkg::ccsp_cmd_t cmd;
	logic dma_done = 1'h0;
	logic rvalid, cmd_valid, dma_start, dma_active;
	logic [7:0] rdata, ram_addr;
	logic [4:0] buf_index;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	// ==========================================
	// Design and CPU
	ccsp_port uut (.CLK(CLK), .RST(RST), .SFR_REQ(req),
		.IRQ_FLAGS(irq), .STATUS_FLAGS(sta), .DMA_DONE(dma_done),
		.SFR_RDATA(rdata), .SFR_RVALID(rvalid), .CMD_STROBE(cmd),
		.CMD_VALID(cmd_valid), .DMA_START(dma_start),
		.DMA_RAM_ADDR(ram_addr), .DMA_BUF_INDEX(buf_index),
		.DMA_ACTIVE(dma_active));
	ccsp_cpu_model cpu (.CLK(CLK), .SFR_RDATA(rdata),
		.SFR_RVALID(rvalid), .SFR_REQ(req));
	initial forever #50 CLK = ~CLK;
	// ==========================================
	// Helpers
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, e);
		n_tests++;
		if (s !== e)
		begin
			failures++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic rdc(input logic [7:0] a, e);
		logic [7:0] q;
		cpu.rd(a, q);
		chk(q, e);
	endtask
	task automatic wr(input logic [7:0] a, d);
		cpu.cyc(1'h0, 1'h1, 1'h0, a, d);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_sel;
		rdc(8'hDB, 8'h64); // reset
		wr(8'hDB, 8'h00);
		rdc(8'hDB, 8'h40); // reserved
		rdc(8'h80, 8'hFF); // unmapped
	endtask
	task automatic t_win;
		wr(8'hDB, 8'h23);
		wr(8'hDA, 8'hA5);
		wr(8'hDA, 8'h5A);
		rdc(8'hDB, 8'h65); // stepped
		wr(8'hDB, 8'h03);
		rdc(8'hDA, 8'hA5); // window
		rdc(8'hDA, 8'hA5); // no step
		wr(8'hDB, 8'h24);
		rdc(8'hDA, 8'h5A); // next entry
		wr(8'hDB, 8'h3F);
		wr(8'hDA, 8'h11);
		rdc(8'hDB, 8'h60); // wraps
	endtask
	task automatic t_flags;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge CLK);
			irq <= ccsp_pkg::ccsp_irq_t'(5'h01 << i);
			sta <= ccsp_pkg::ccsp_status_t'(8'h01 << i);
			if (i < 5)
				rdc(8'hD9, 8'hE0 | (8'h01 << i)); // irq
			rdc(8'hD8, 8'h01 << i); // status
		end
		@(posedge CLK);
		irq <= '{wake_up_irq_flag: 1'h1, default: 1'h0};
		sta <= '{bus_off_state_flag: 1'h1, default: 1'h0};
		rdc(8'hD9, 8'hF0); // wake-up on bit 4
		rdc(8'hD8, 8'h80); // bus status on bit 7
	endtask
	task automatic t_cmd;
		for (int i = 0; i < 8; i++)
		begin
			wr(8'hD9, 8'h01 << i);
			@(negedge CLK);
			chk(cmd, 8'h01 << i); // command
			chk({7'h00, cmd_valid}, 8'h01); // strobe
			@(negedge CLK);
			chk({cmd_valid, cmd[6:0]}, 8'h00); // one cycle
		end
		wr(8'hD9, 8'h88);
		@(negedge CLK);
		chk({7'h00, cmd.first_receive_input_active}, 8'h01); // bit 7
		chk({7'h00, cmd.clear_overrun_cmd}, 8'h01); // bit 3
	endtask
	task automatic t_ram;
		wr(8'hD8, 8'hC3);
		@(negedge CLK);
		chk(ram_addr, 8'hC3); // latch
		cpu.cyc(1'h0, 1'h0, 1'h1, 8'hDF, 8'h00);
		cpu.cyc(1'h0, 1'h0, 1'h1, 8'hD8, 8'h00);
		cpu.cyc(1'h0, 1'h0, 1'h1, 8'hDC, 8'h01);
		@(negedge CLK);
		chk(ram_addr, 8'h52); // bits
	endtask
	task automatic t_dma;
		wr(8'hDB, 8'h8A);
		@(negedge CLK);
		chk({dma_start, 2'h0, buf_index}, 8'h8A); // start
		@(negedge CLK);
		chk({6'h00, dma_start, dma_active}, 8'h01); // busy
		@(posedge CLK);
		dma_done <= 1'h1;
		@(posedge CLK);
		dma_done <= 1'h0;
		repeat (3) @(negedge CLK);
		chk({7'h00, dma_active}, 8'h00); // done
		rdc(8'hDB, 8'h4A); // cleared
	endtask
	// Reset in mid-run brings back the selector and clears outputs
	task automatic t_rst;
		wr(8'hDB, 8'h25);
		@(posedge CLK);
		RST <= 1'h1;
		repeat (2) @(posedge CLK);
		RST <= 1'h0;
		@(negedge CLK);
		chk({dma_active, 2'h0, buf_index}, 8'h00); // cleared
		chk(ram_addr, 8'h00); // cleared
		rdc(8'hDB, 8'h64); // selector
	endtask
	// ==========================================
	// Main sequence and hang guard
	initial
	begin
		repeat (12) @(posedge CLK);
		RST <= 1'h0;
		t_sel();
		t_win();
		t_flags();
		t_cmd();
		t_ram();
		t_dma();
		t_rst();
		conclude();
	end
	// Run needs fewer than two hundred cycles
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			failures++;
			conclude();
		end
	end
endmodule
